// ==== rtl/sbw_alu.sv ====
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
// Overview of operation
// [RL1] code 412: result word = left - right - borrow, 16 bits.
// [RL2] code 413: 32-bit left - right - borrow into the result pair.
// [RL3] negative difference stays two's complement and sets borrow.
// [RL4] zero flag set when full-width result is zero, else cleared.
// [RL5] borrow flag set on borrow out of the top bit, else cleared.
// [RL6] word: positive minus negative giving 8000..FFFF sets overflow.
// [RL7] dword: positive minus negative giving 80000000..FFFFFFFF sets overflow.
// [RL8] word: negative minus positive giving 0000..7FFF sets underflow.
// [RL9] dword: negative minus positive giving 00000000..7FFFFFFF sets underflow.
// [RL10] negative flag copies the top bit of the result at active width.
// [RL11] signed subtract with borrow always clears the error flag.
// [RL12] code 041 forces the borrow flag to zero.
// [RL13] word forms use one word per operand, dword forms two words.
// [RL14] codes 414 and 415: four and eight digit decimal subtract, no borrow in.
// [RL15] decimal forms raise error when any source digit is above nine.
// [RL16] decimal negative difference is ten's complement and sets borrow.
// [RL17] lower word of a pair holds the low 16 bits.
module sbw_alu (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic IRQ,
	output logic [5:0] FLAGS
);
	// ==========================================
	// bus state
	sbw_pkg::sbw_bus_st_e st_q;
	logic wr_pend_q;
	logic [7:0] addr_q;
	logic take;
	logic wr_take;
	logic rd_take;
	logic [31:0] rd_mux;

	// ==========================================
	// programmer visible state
	logic [11:0] opcode_q;
	logic [15:0] left_lo_q;
	logic [15:0] left_hi_q;
	logic [15:0] right_lo_q;
	logic [15:0] right_hi_q;
	logic [15:0] res_lo_q;
	logic [15:0] res_hi_q;
	logic [5:0] flags_q;
	logic [2:0] irq_stat_q;
	logic [2:0] irq_en_q;

	// ==========================================
	// write strobes, valid in the data phase
	logic wr_ctrl;
	logic wr_clear;
	logic exec_go;
	logic [2:0] irq_ev;
	logic [2:0] irq_clr;

	// ==========================================
	// datapath nets
	logic [16:0] sw_diff;
	logic [32:0] dw_diff;
	logic [31:0] left_dw;
	logic [31:0] right_dw;
	logic [7:0] dg_bin;
	logic [7:0] dg_bout;
	logic [7:0] dg_bad;
	logic [31:0] dg_res;
	logic bcd_bad_w;
	logic bcd_bad_d;
	logic known_op;

	// ==========================================
	// bus address phase
	always_comb begin
		take = HSEL & HREADY & (HTRANS == sbw_pkg::HTRANS_NONSEQ);
		wr_take = take & HWRITE & (HSIZE == sbw_pkg::HSIZE_WORD);
		rd_take = take & ~HWRITE;
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_pend_q <= wr_take;
			if (take) begin
				addr_q <= HADDR[7:0];
			end
		end
	end

	// reads wait one cycle so a write just before is visible
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			st_q <= sbw_pkg::ST_IDLE;
			HREADYOUT <= 1'b1;
			HRDATA <= 32'h0000_0000;
		end else begin
			case (st_q)
				sbw_pkg::ST_IDLE: begin
					if (rd_take) begin
						st_q <= sbw_pkg::ST_RWAIT;
						HREADYOUT <= 1'b0;
					end
				end
				sbw_pkg::ST_RWAIT: begin
					st_q <= sbw_pkg::ST_IDLE;
					HREADYOUT <= 1'b1;
					HRDATA <= rd_mux;
				end
				default: begin
					st_q <= sbw_pkg::ST_IDLE;
					HREADYOUT <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			HRESP <= 1'b0;
		end else begin
			HRESP <= 1'b0;
		end
	end

	// ==========================================
	// read multiplexer, unmapped reads as zero
	always_comb begin
		case (addr_q)
			sbw_pkg::OFS_CTRL: rd_mux = {20'h00000, opcode_q};
			sbw_pkg::OFS_LEFT_LO: rd_mux = {16'h0000, left_lo_q};
			sbw_pkg::OFS_LEFT_HI: rd_mux = {16'h0000, left_hi_q};
			sbw_pkg::OFS_RIGHT_LO: rd_mux = {16'h0000, right_lo_q};
			sbw_pkg::OFS_RIGHT_HI: rd_mux = {16'h0000, right_hi_q};
			sbw_pkg::OFS_RES_LO: rd_mux = {16'h0000, res_lo_q};
			sbw_pkg::OFS_RES_HI: rd_mux = {16'h0000, res_hi_q};
			sbw_pkg::OFS_FLAGS: rd_mux = {26'h0000000, flags_q};
			sbw_pkg::OFS_IRQ_STATUS: rd_mux = {29'h00000000, irq_stat_q};
			sbw_pkg::OFS_IRQ_ENABLE: rd_mux = {29'h00000000, irq_en_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// ==========================================
	// write decode
	always_comb begin
		wr_ctrl = wr_pend_q & (addr_q == sbw_pkg::OFS_CTRL);
		wr_clear = wr_pend_q & (addr_q == sbw_pkg::OFS_IRQ_CLEAR);
		known_op = (HWDATA[11:0] == sbw_pkg::OP_SIGNED_SUB_BORROW_WORD)
			| (HWDATA[11:0] == sbw_pkg::OP_SIGNED_SUB_BORROW_DWORD)
			| (HWDATA[11:0] == sbw_pkg::OP_DECIMAL_SUB_WORD)
			| (HWDATA[11:0] == sbw_pkg::OP_DECIMAL_SUB_DWORD)
			| (HWDATA[11:0] == sbw_pkg::OP_CLEAR_BORROW);
		exec_go = wr_ctrl & known_op;
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			opcode_q <= 12'h000;
		end else if (wr_ctrl) begin
			opcode_q <= HWDATA[11:0];
		end
	end

	// [RL13] operand words
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			left_lo_q <= 16'h0000;
			left_hi_q <= 16'h0000;
			right_lo_q <= 16'h0000;
			right_hi_q <= 16'h0000;
		end else if (wr_pend_q) begin
			case (addr_q)
				sbw_pkg::OFS_LEFT_LO: left_lo_q <= HWDATA[15:0];
				sbw_pkg::OFS_LEFT_HI: left_hi_q <= HWDATA[15:0];
				sbw_pkg::OFS_RIGHT_LO: right_lo_q <= HWDATA[15:0];
				sbw_pkg::OFS_RIGHT_HI: right_hi_q <= HWDATA[15:0];
				default: begin
				end
			endcase
		end
	end

	// ==========================================
	// binary subtract with borrow
	always_comb begin
		// [RL17] low word holds low bits
		left_dw = {left_hi_q, left_lo_q};
		right_dw = {right_hi_q, right_lo_q};
		// [RL1] word difference
		sw_diff = {1'b0, left_lo_q} - {1'b0, right_lo_q}
			- {16'h0000, flags_q[sbw_pkg::FB_BORROW]};
		// [RL2] dword difference
		dw_diff = {1'b0, left_dw} - {1'b0, right_dw}
			- {32'h0000_0000, flags_q[sbw_pkg::FB_BORROW]};
	end

	// ==========================================
	// decimal subtract, no borrow in
	// [RL14] digit chain
	genvar gi;
	generate
		for (gi = 0; gi < sbw_pkg::DIGITS; gi++) begin : g_dig
			if (gi == 0) begin : g_first
				assign dg_bin[gi] = 1'b0;
			end else begin : g_next
				assign dg_bin[gi] = dg_bout[gi-1];
			end
			sbw_bcd_digit u_dig (
				.a(left_dw[4*gi+3:4*gi]),
				.b(right_dw[4*gi+3:4*gi]),
				.bin(dg_bin[gi]),
				.d(dg_res[4*gi+3:4*gi]),
				.bout(dg_bout[gi]),
				.bad(dg_bad[gi])
			);
		end
	endgenerate

	// [RL15] invalid digit check
	always_comb begin
		bcd_bad_w = |dg_bad[sbw_pkg::DIGITS_WORD-1:0];
		bcd_bad_d = |dg_bad;
	end

	// ==========================================
	// result and flag update
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			res_lo_q <= 16'h0000;
			res_hi_q <= 16'h0000;
			flags_q <= sbw_pkg::FLAGS_RESET;
		end else if (exec_go) begin
			case (HWDATA[11:0])
				sbw_pkg::OP_SIGNED_SUB_BORROW_WORD: begin
					// [RL3] two's complement kept
					res_lo_q <= sw_diff[15:0];
					// [RL11] error cleared
					flags_q[sbw_pkg::FB_ERROR] <= 1'b0;
					// [RL4] zero test
					flags_q[sbw_pkg::FB_ZERO] <= (sw_diff[15:0] == 16'h0000);
					// [RL5] borrow out
					flags_q[sbw_pkg::FB_BORROW] <= sw_diff[16];
					// [RL6] word overflow
					flags_q[sbw_pkg::FB_OVERFLOW] <= ~left_lo_q[15] & right_lo_q[15] & sw_diff[15];
					// [RL8] word underflow
					flags_q[sbw_pkg::FB_UNDERFLOW] <= left_lo_q[15] & ~right_lo_q[15] & ~sw_diff[15];
					// [RL10] sign copy
					flags_q[sbw_pkg::FB_NEGATIVE] <= sw_diff[15];
				end
				sbw_pkg::OP_SIGNED_SUB_BORROW_DWORD: begin
					// [RL3] two's complement pair
					res_lo_q <= dw_diff[15:0];
					res_hi_q <= dw_diff[31:16];
					// [RL11] error cleared
					flags_q[sbw_pkg::FB_ERROR] <= 1'b0;
					// [RL4] zero test
					flags_q[sbw_pkg::FB_ZERO] <= (dw_diff[31:0] == 32'h0000_0000);
					// [RL5] borrow out
					flags_q[sbw_pkg::FB_BORROW] <= dw_diff[32];
					// [RL7] dword overflow
					flags_q[sbw_pkg::FB_OVERFLOW] <= ~left_hi_q[15] & right_hi_q[15] & dw_diff[31];
					// [RL9] dword underflow
					flags_q[sbw_pkg::FB_UNDERFLOW] <= left_hi_q[15] & ~right_hi_q[15] & ~dw_diff[31];
					// [RL10] sign copy
					flags_q[sbw_pkg::FB_NEGATIVE] <= dw_diff[31];
				end
				sbw_pkg::OP_DECIMAL_SUB_WORD: begin
					// [RL15] error only, result kept
					flags_q[sbw_pkg::FB_ERROR] <= bcd_bad_w;
					if (!bcd_bad_w) begin
						// [RL16] ten's complement and borrow
						res_lo_q <= dg_res[15:0];
						flags_q[sbw_pkg::FB_ZERO] <= (dg_res[15:0] == 16'h0000);
						flags_q[sbw_pkg::FB_BORROW] <= dg_bout[sbw_pkg::DIGITS_WORD-1];
					end
				end
				sbw_pkg::OP_DECIMAL_SUB_DWORD: begin
					// [RL15] error only, result kept
					flags_q[sbw_pkg::FB_ERROR] <= bcd_bad_d;
					if (!bcd_bad_d) begin
						// [RL16] ten's complement and borrow
						res_lo_q <= dg_res[15:0];
						res_hi_q <= dg_res[31:16];
						flags_q[sbw_pkg::FB_ZERO] <= (dg_res == 32'h0000_0000);
						flags_q[sbw_pkg::FB_BORROW] <= dg_bout[sbw_pkg::DIGITS-1];
					end
				end
				sbw_pkg::OP_CLEAR_BORROW: begin
					// [RL12] clear borrow
					flags_q[sbw_pkg::FB_BORROW] <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			FLAGS <= sbw_pkg::FLAGS_RESET;
		end else begin
			FLAGS <= flags_q;
		end
	end

	// ==========================================
	// interrupt events, set wins over clear
	always_comb begin
		irq_ev = sbw_pkg::IRQ_RESET;
		irq_ev[sbw_pkg::IB_DONE] = exec_go;
		irq_ev[sbw_pkg::IB_BAD_OP] = wr_ctrl & ~known_op;
		if (exec_go && (HWDATA[11:0] == sbw_pkg::OP_DECIMAL_SUB_WORD)) begin
			irq_ev[sbw_pkg::IB_ERROR] = bcd_bad_w;
		end
		if (exec_go && (HWDATA[11:0] == sbw_pkg::OP_DECIMAL_SUB_DWORD)) begin
			irq_ev[sbw_pkg::IB_ERROR] = bcd_bad_d;
		end
		irq_clr = wr_clear ? HWDATA[2:0] : sbw_pkg::IRQ_RESET;
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			irq_stat_q <= sbw_pkg::IRQ_RESET;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			irq_en_q <= sbw_pkg::IRQ_RESET;
		end else if (wr_pend_q && (addr_q == sbw_pkg::OFS_IRQ_ENABLE)) begin
			irq_en_q <= HWDATA[2:0];
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(irq_stat_q & irq_en_q);
		end
	end
endmodule

// ==== rtl/sbw_bcd_digit.sv ====
`timescale 1ns/10ps
// ==========================================
// one decimal digit of a chained subtractor
module sbw_bcd_digit (
	input wire logic [3:0] a,
	input wire logic [3:0] b,
	input wire logic bin,
	output logic [3:0] d,
	output logic bout,
	output logic bad
);
	logic [4:0] raw;

	always_comb begin
		raw = {1'b0, a} - {1'b0, b} - {4'h0, bin};
		bout = raw[4];
		// a negative digit wraps by adding ten
		if (raw[4]) begin
			d = raw[3:0] + sbw_pkg::BCD_TEN;
		end else begin
			d = raw[3:0];
		end
		bad = (a > sbw_pkg::BCD_MAX) | (b > sbw_pkg::BCD_MAX);
	end
endmodule

// ==== rtl/sbw_pkg.sv ====
// ==========================================
// register map and constants
package sbw_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LEFT_LO = 8'h04;
	localparam logic [7:0] OFS_LEFT_HI = 8'h08;
	localparam logic [7:0] OFS_RIGHT_LO = 8'h0C;
	localparam logic [7:0] OFS_RIGHT_HI = 8'h10;
	localparam logic [7:0] OFS_RES_LO = 8'h14;
	localparam logic [7:0] OFS_RES_HI = 8'h18;
	localparam logic [7:0] OFS_FLAGS = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;

	// ==========================================
	// function codes, written as printed digits
	localparam logic [11:0] OP_SIGNED_SUB_BORROW_WORD = 12'h412;
	localparam logic [11:0] OP_SIGNED_SUB_BORROW_DWORD = 12'h413;
	localparam logic [11:0] OP_DECIMAL_SUB_WORD = 12'h414;
	localparam logic [11:0] OP_DECIMAL_SUB_DWORD = 12'h415;
	localparam logic [11:0] OP_CLEAR_BORROW = 12'h041;

	// ==========================================
	// flag register bit positions
	localparam int FLAG_W = 6;
	localparam int FB_ERROR = 0;
	localparam int FB_ZERO = 1;
	localparam int FB_BORROW = 2;
	localparam int FB_OVERFLOW = 3;
	localparam int FB_UNDERFLOW = 4;
	localparam int FB_NEGATIVE = 5;
	localparam logic [5:0] FLAGS_RESET = 6'h00;

	// ==========================================
	// interrupt status bit positions
	localparam int IRQ_W = 3;
	localparam int IB_DONE = 0;
	localparam int IB_ERROR = 1;
	localparam int IB_BAD_OP = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	// ==========================================
	// datapath sizes and bus codes
	localparam int WORD_W = 16;
	localparam int DIGITS = 8;
	localparam int DIGITS_WORD = 4;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [3:0] BCD_TEN = 4'hA;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RWAIT = 2'b10
	} sbw_bus_st_e;
endpackage

// ==== verification/sbw_alu_assertions.sv ====
`timescale 1ns/10ps
// ==========================================
// flag and bus checks on the top ports
module sbw_chk (
	input logic MCLK,
	input logic RST,
	input logic HSEL,
	input logic [31:0] HADDR,
	input logic [1:0] HTRANS,
	input logic HWRITE,
	input logic [2:0] HSIZE,
	input logic [31:0] HWDATA,
	input logic HREADY,
	input logic HREADYOUT,
	input logic HRESP,
	input logic [5:0] FLAGS
);
	logic req;
	logic ctl;
	assign req = HSEL && HREADY && HTRANS == sbw_pkg::HTRANS_NONSEQ;
	assign ctl = req && HWRITE && HSIZE == sbw_pkg::HSIZE_WORD && HADDR[7:0] == sbw_pkg::OFS_CTRL;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	// ==========================================
	// flag layout: 0 err 1 zero 2 borrow 3 ovf 4 unf 5 neg
	sequence s_sgn;
		ctl ##1 (HWDATA[11:0] == 12'h412 || HWDATA[11:0] == 12'h413);
	endsequence
	sequence s_clr;
		ctl ##1 HWDATA[11:0] == sbw_pkg::OP_CLEAR_BORROW;
	endsequence
	property p_no_err;
		s_sgn |-> ##2 !FLAGS[0];
	endproperty
	property p_clr;
		s_clr |-> ##2 !FLAGS[2];
	endproperty
	property p_excl;
		!(FLAGS[3] && FLAGS[4]);
	endproperty
	property p_ovf_neg;
		s_sgn |-> ##2 (!FLAGS[3] || FLAGS[5]);
	endproperty
	property p_unf_pos;
		s_sgn |-> ##2 (!FLAGS[4] || !FLAGS[5]);
	endproperty
	property p_zero_pos;
		s_sgn |-> ##2 (!FLAGS[1] || !FLAGS[5]);
	endproperty
	property p_rd;
		req && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
	endproperty
	property p_wr;
		req && HWRITE |=> HREADYOUT && !HRESP;
	endproperty
	a_no_err: assert property (p_no_err) else $error("error flag after signed op");
	a_clr: assert property (p_clr) else $error("borrow kept after clear");
	a_excl: assert property (p_excl) else $error("overflow and underflow together");
	a_ovf_neg: assert property (p_ovf_neg) else $error("overflow with positive result");
	a_unf_pos: assert property (p_unf_pos) else $error("underflow with negative result");
	a_zero_pos: assert property (p_zero_pos) else $error("zero with negative flag");
	a_rd: assert property (p_rd) else $error("read wait wrong");
	a_wr: assert property (p_wr) else $error("write wait or response wrong");
endmodule
bind sbw_alu sbw_chk u_chk (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
	.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
	.HRESP(HRESP), .FLAGS(FLAGS));

// ==== verification/sbw_alu_tb.sv ====
`timescale 1ns/10ps
// ==========================================
// random and corner subtract runs
module sbw_alu_tb;
	logic MCLK = 0, RST = 1, HSEL = 0, HWRITE = 0, HREADYOUT, HRESP, IRQ;
	logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, res_m = 0, q;
	logic [1:0] HTRANS = 0;
	logic [2:0] HSIZE = 0;
	logic [2:0] hsz = sbw_pkg::HSIZE_WORD;
	logic [5:0] FLAGS, flg_m = 0;
	logic [11:0] op;
	logic [11:0] ops [5] = '{12'h412, 12'h413, 12'h414, 12'h415, 12'h041};
	int failures = 0, n_checks = 0;
	always #25 MCLK = ~MCLK;
	sbw_alu dut (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .IRQ(IRQ), .FLAGS(FLAGS));
	// ==========================================
	// bus and compare
	task chk(string n, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task xfer(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge MCLK);
		HSEL <= 1;
		HTRANS <= sbw_pkg::HTRANS_NONSEQ;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		HSIZE <= hsz;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HSEL <= 0;
		HWDATA <= d;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		q = HRDATA;
	endtask
	task irqc(string n, logic e);
		repeat (3) @(posedge MCLK);
		chk(n, {31'h0, e}, {31'h0, IRQ});
	endtask
	// ==========================================
	// expected results
	function automatic void sgn(logic dw, logic [31:0] l, logic [31:0] r);
		int w = dw ? 32 : 16;
		logic [31:0] m = dw ? 32'hFFFFFFFF : 32'h0000FFFF;
		logic [32:0] d = {1'b0, l & m} - {1'b0, r & m} - flg_m[2];
		logic t = d[w - 1];
		res_m = dw ? d[31:0] : {res_m[31:16], d[15:0]};
		flg_m = {t, l[w - 1] & ~r[w - 1] & ~t, ~l[w - 1] & r[w - 1] & t, d[w], (d[31:0] & m) == 0, 1'b0};
	endfunction
	function automatic void dec(logic dw, logic [31:0] l, logic [31:0] r);
		longint a = 0, c = 0, p = 1;
		logic bad = 0;
		logic [31:0] o = 0;
		for (int i = (dw ? 7 : 3); i >= 0; i--) begin
			bad |= (l[4*i+:4] > 9) | (r[4*i+:4] > 9);
			a = a * 10 + l[4*i+:4];
			c = c * 10 + r[4*i+:4];
			p *= 10;
		end
		flg_m[0] = bad;
		if (!bad) begin
			a -= c;
			flg_m[2] = a < 0;
			a += flg_m[2] ? p : 0;
			flg_m[1] = a == 0;
			for (int i = 0; i < 8; i++) begin
				o[4*i+:4] = 4'(a % 10);
				a /= 10;
			end
			res_m = dw ? o : {res_m[31:16], o[15:0]};
		end
	endfunction
	function automatic logic [31:0] rb();
		logic [31:0] v;
		for (int i = 0; i < 8; i++)
			v[4*i+:4] = 4'($urandom % 10);
		return v;
	endfunction
	task one(logic [11:0] c, logic [31:0] l, logic [31:0] r);
		xfer(1, sbw_pkg::OFS_LEFT_LO, {16'h0, l[15:0]});
		xfer(1, sbw_pkg::OFS_LEFT_HI, {16'h0, l[31:16]});
		xfer(1, sbw_pkg::OFS_RIGHT_LO, {16'h0, r[15:0]});
		xfer(1, sbw_pkg::OFS_RIGHT_HI, {16'h0, r[31:16]});
		xfer(1, sbw_pkg::OFS_CTRL, {20'h0, c});
		case (c)
			12'h412: sgn(0, l, r);
			12'h413: sgn(1, l, r);
			12'h414: dec(0, l, r);
			12'h415: dec(1, l, r);
			default: flg_m[2] = 0;
		endcase
		xfer(0, sbw_pkg::OFS_RES_LO, 0);
		chk("res_lo", {16'h0, res_m[15:0]}, q);
		xfer(0, sbw_pkg::OFS_RES_HI, 0);
		chk("res_hi", {16'h0, res_m[31:16]}, q);
		xfer(0, sbw_pkg::OFS_FLAGS, 0);
		chk("flags", {26'h0, flg_m}, q);
		chk("flag_pins", {26'h0, flg_m}, {26'h0, FLAGS});
	endtask
	task complete_run;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(32'h6186));
		repeat (16) @(posedge MCLK);
		RST <= 0;
		one(12'h412, 32'h0000_7FFF, 32'h0000_FFFF);
		one(12'h412, 32'h0000_0005, 32'h0000_0004);
		one(12'h412, 32'h0000_8000, 32'h0000_0001);
		one(12'h413, 32'h7FFF_FFFF, 32'hFFFF_FFFF);
		one(12'h041, 0, 0);
		one(12'h413, 32'h8000_0000, 32'h0000_0001);
		one(12'h413, 32'h20F5_5A10, 32'hB8A3_60E3);
		one(12'h415, 32'h0958_3960, 32'h1707_2641);
		one(12'h414, 32'h0000_12A4, 32'h0000_0001);
		one(12'h414, 32'h0000_1234, 32'h0000_1234);
		repeat (60) begin
			op = ops[$urandom % 5];
			one(op, op[2] ? rb() : $urandom, op[2] ? rb() : $urandom);
		end
		xfer(1, sbw_pkg::OFS_IRQ_CLEAR, 32'h7);
		one(12'h414, 32'h0000_0A00, 32'h0000_0001);
		xfer(0, sbw_pkg::OFS_IRQ_STATUS, 0);
		chk("dec_err_irq", 32'h3, q);
		one(12'h412, 32'h0000_0000, 32'h0000_0000);
		xfer(1, sbw_pkg::OFS_LEFT_LO, 32'h5A5A);
		hsz = 3'h0;
		xfer(1, sbw_pkg::OFS_LEFT_LO, 32'h1234);
		hsz = sbw_pkg::HSIZE_WORD;
		xfer(0, sbw_pkg::OFS_LEFT_LO, 0);
		chk("narrow_wr", 32'h5A5A, q);
		xfer(1, sbw_pkg::OFS_IRQ_CLEAR, 32'h7);
		xfer(1, sbw_pkg::OFS_IRQ_ENABLE, 32'h4);
		xfer(1, sbw_pkg::OFS_CTRL, 32'h123);
		irqc("irq_set", 1);
		xfer(0, sbw_pkg::OFS_IRQ_STATUS, 0);
		chk("bad_op", 32'h4, q);
		xfer(1, sbw_pkg::OFS_IRQ_CLEAR, 32'h4);
		irqc("irq_clr", 0);
		xfer(1, sbw_pkg::OFS_IRQ_ENABLE, 32'h0);
		xfer(1, sbw_pkg::OFS_CTRL, 32'h123);
		irqc("irq_mask", 0);
		xfer(0, 8'h40, 0);
		chk("unmapped", 0, q);
		complete_run;
	end
	initial begin
		#1500000;
		failures++;
		complete_run;
	end
endmodule
